/* hw/hdlcr_pkg.sv */
package hdlcr_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int         ADDR_W     = 10;
  localparam int         DATA_W     = 32;
  localparam logic [7:0] IDX_CFG    = 8'hC0;
  localparam logic [7:0] IDX_IRQC   = 8'hC1;
  localparam logic [7:0] IDX_STAT   = 8'hC2;
  localparam logic [7:0] IDX_DATA   = 8'hC3;
  localparam logic [7:0] IDX_PRI    = 8'hC4;
  localparam logic [7:0] IDX_SEC    = 8'hC5;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         CFG_W      = 5;
  localparam int         CFG_EN     = 0;
  localparam int         CFG_TERM   = 1;
  localparam int         CFG_MASK   = 2;
  localparam int         CFG_MATCH  = 3;
  localparam int         IRQC_IE    = 7;
  localparam int         FILL_W     = 7;
  localparam int         ST_EMPTY   = 7;
  localparam int         ST_OVERRUN = 6;
  localparam int         ST_LC      = 5;
  localparam int         ST_PKT     = 4;
  localparam int         ST_IRQ     = 0;
  localparam logic [4:0] CFG_RST    = 5'h00;
  localparam logic [7:0] IRQC_RST   = 8'h00;
  localparam logic [7:0] PRI_RST    = 8'hFF;
  localparam logic [7:0] SEC_RST    = 8'hFF;
  // ---------------------------------------------------------------
  // packet byte codes
  // ---------------------------------------------------------------
  localparam logic [2:0] PBC_DATA   = 3'h0;
  localparam logic [2:0] PBC_UP     = 3'h1;
  localparam logic [2:0] PBC_DOWN   = 3'h2;
  localparam logic [2:0] PBC_GOOD   = 3'h4;
  localparam logic [2:0] PBC_NONINT = 3'h5;
  localparam logic [2:0] PBC_CRC    = 3'h6;
  localparam logic [2:0] PBC_BOTH   = 3'h7;
  // ---------------------------------------------------------------
  // line coding
  // ---------------------------------------------------------------
  localparam logic [7:0]  FLAG_SEQ   = 8'h7E;
  localparam logic [7:0]  ABORT_SEQ  = 8'hFE;
  localparam logic [7:0]  ALL_ONES   = 8'hFF;
  localparam logic [7:0]  MATCH_MASK = 8'hFC;
  localparam logic [7:0]  DUMMY_BYTE = 8'h00;
  localparam logic [15:0] CRC_INIT   = 16'hFFFF;
  localparam logic [15:0] CRC_POLY   = 16'h8408;
  localparam logic [15:0] CRC_GOOD   = 16'hF0B8;
  localparam logic [2:0]  STUFF_RUN  = 3'h5;
  localparam logic [3:0]  SKIP_SEQ   = 4'h7;
  localparam logic [1:0]  HOLD_LAST  = 2'h3;
  localparam int          FIFO_DEPTH = 128;

  typedef enum logic [1:0] {HDLCR_HUNT, HDLCR_FRAME, HDLCR_DROP} hdlcr_rx_state_t;
endpackage : hdlcr_pkg

/* hw/hdlcr_rx.sv */
`timescale 1ns/1ns
// Summary of operation
// - disabled: fifo empty, interrupt sources cleared
// - enable set: start hunting for flag
// - terminate bit restarts like disable then enable
// - after restart, first flag raises interrupt
// - terminate bit clears itself, reads zero
// - match enable stores only matching first bytes
// - match mask ignores two low address bits
// - fill level zero means 128 bytes
// - interrupt output only while irq enable set
// - pending interrupt at fill threshold
// - pending interrupt on overrun, packet end, link change
// - byte code describes last byte read
// - link-up flag and link-down abort write tagged dummy bytes
// - end codes for odd bits and crc error
// - packet done set whenever an end code is pushed, good or errored, read clears
// - link change on flag/abort, read clears
// - overrun sticky until status read
// - overrun holds receiver and fifo in reset
// - empty flag tracks fifo contents
// - 128-byte fifo, bit 0 first received
// - address compare on first byte after flag
module hdlcr_rx #(
  parameter int DEPTH = hdlcr_pkg::FIFO_DEPTH
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  input  wire logic                          ce,
  input  wire logic [hdlcr_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [hdlcr_pkg::DATA_W-1:0]  avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [hdlcr_pkg::DATA_W-1:0]  avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic                          dl_data,
  input  wire logic                          dl_valid,
  output logic                               irq_out_n
);
  localparam int             AW      = $clog2(DEPTH);
  localparam int             CW      = AW + 1;
  localparam logic [CW-1:0]  ONE_C   = CW'(1);
  localparam logic [CW-1:0]  DEPTH_C = CW'(DEPTH);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [hdlcr_pkg::CFG_W-1:0] cfg;
    logic [7:0]                  irqc;
    logic [7:0]                  pri;
    logic [7:0]                  sec;
    logic                        wt;
    logic [7:0]                  rdata;
    logic                        irq_n;
    logic                        d_s1;
    logic                        d_s2;
    logic                        v_s1;
    logic                        v_s2;
    logic [7:0]                  win;
    logic [3:0]                  skip;
    logic [2:0]                  ones;
    hdlcr_pkg::hdlcr_rx_state_t  st;
    logic                        active;
    logic [7:0]                  sh;
    logic [2:0]                  bitcnt;
    logic [1:0]                  nb;
    logic [7:0]                  h0;
    logic [7:0]                  h1;
    logic [7:0]                  h2;
    logic [15:0]                 crc;
    logic [15:0]                 crcb;
    logic                        first;
    logic [DEPTH-1:0][10:0]      mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [CW-1:0]               cnt;
    logic [2:0]                  code;
    logic                        pkt;
    logic                        lc;
    logic                        overrun;
    logic                        irqp;
  } hdlcr_regs_t;

  hdlcr_regs_t   s;
  hdlcr_regs_t   n;
  logic [7:0]    idx;
  logic          req;
  logic          rst_rx;
  logic [CW-1:0] thr;
  logic [7:0]    cand;
  logic [7:0]    amask;
  logic          hit;
  logic          push;
  logic          push_ok;
  logic          pop;
  logic [2:0]    pcode;
  logic [7:0]    pbyte;
  logic [7:0]    clr;
  logic [7:0]    rdv;
  logic          ob;
  logic          fb;
  logic          irq_raw;

  assign idx    = avs_address[hdlcr_pkg::ADDR_W-1:2];
  assign req    = avs_read | avs_write;
  // overrun, disable and terminate all share one reset path
  assign rst_rx = ~s.cfg[hdlcr_pkg::CFG_EN] | s.cfg[hdlcr_pkg::CFG_TERM] | s.overrun;
  assign thr    = (s.irqc[hdlcr_pkg::FILL_W-1:0] == 7'h00) ? DEPTH_C
                : CW'(s.irqc[hdlcr_pkg::FILL_W-1:0]);
  assign cand   = {s.win[0], s.sh[7:1]};
  assign amask  = s.cfg[hdlcr_pkg::CFG_MASK] ? hdlcr_pkg::MATCH_MASK : hdlcr_pkg::ALL_ONES;
  assign hit    = ((cand & amask) == (s.pri & amask))
               || ((cand & amask) == (s.sec & amask))
               || ((cand & amask) == (hdlcr_pkg::ALL_ONES & amask));
  assign irq_raw = s.irqp & s.irqc[hdlcr_pkg::IRQC_IE];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n       = s;
    push    = 1'b0;
    push_ok = 1'b0;
    pop     = 1'b0;
    pcode   = hdlcr_pkg::PBC_DATA;
    pbyte   = hdlcr_pkg::DUMMY_BYTE;
    clr     = 8'h00;
    rdv     = 8'h00;
    ob      = s.win[0];
    fb      = 1'b0;
    n.d_s1  = dl_data;
    n.d_s2  = s.d_s1;
    n.v_s1  = dl_valid;
    n.v_s2  = s.v_s1;

    // bus: capture read data in the wait cycle, act at the release
    case (idx)
      hdlcr_pkg::IDX_CFG: begin
        rdv = {3'h0, s.cfg};
        rdv[hdlcr_pkg::CFG_TERM] = 1'b0;
      end
      hdlcr_pkg::IDX_IRQC: rdv = s.irqc;
      hdlcr_pkg::IDX_STAT: rdv = {(s.cnt == '0), s.overrun, s.lc, s.pkt, s.code, s.irqp};
      hdlcr_pkg::IDX_DATA: rdv = s.mem[s.rp][7:0];
      hdlcr_pkg::IDX_PRI:  rdv = s.pri;
      hdlcr_pkg::IDX_SEC:  rdv = s.sec;
      default:             rdv = 8'h00;
    endcase
    n.wt = 1'b1;
    if (req && s.wt) begin
      n.wt    = 1'b0;
      n.rdata = rdv;
    end
    if (req && !s.wt && avs_write && avs_byteenable[0]) begin
      case (idx)
        hdlcr_pkg::IDX_CFG:  n.cfg  = avs_writedata[hdlcr_pkg::CFG_W-1:0];
        hdlcr_pkg::IDX_IRQC: n.irqc = avs_writedata[7:0];
        hdlcr_pkg::IDX_PRI:  n.pri  = avs_writedata[7:0];
        hdlcr_pkg::IDX_SEC:  n.sec  = avs_writedata[7:0];
        default: begin
        end
      endcase
    end
    if (req && !s.wt && avs_read) begin
      // only the flags that were reported get cleared
      if (idx == hdlcr_pkg::IDX_STAT) clr = s.rdata;
      if (idx == hdlcr_pkg::IDX_DATA && s.cnt != '0) pop = 1'b1;
    end
    if (pop) begin
      n.code = s.mem[s.rp][10:8];
      n.rp   = s.rp + 1'b1;
    end
    if (clr[hdlcr_pkg::ST_PKT]) n.pkt = 1'b0;
    if (clr[hdlcr_pkg::ST_LC])  n.lc = 1'b0;
    if (clr[hdlcr_pkg::ST_OVERRUN]) n.overrun = 1'b0;
    if (clr[hdlcr_pkg::ST_IRQ]) n.irqp = 1'b0;

    // ---------------------------------------------------------------
    // receiver: flags seen on the window, data taken from its far end
    // ---------------------------------------------------------------
    if (!rst_rx && s.v_s2) begin
      n.win = {s.d_s2, s.win[7:1]};
      if (s.win == hdlcr_pkg::FLAG_SEQ) begin
        n.skip = hdlcr_pkg::SKIP_SEQ;
        if (!s.active) begin
          push     = 1'b1;
          pcode    = hdlcr_pkg::PBC_UP;
          n.active = 1'b1;
          n.lc     = 1'b1;
        end else if (s.st == hdlcr_pkg::HDLCR_FRAME && s.nb == hdlcr_pkg::HOLD_LAST) begin
          push  = 1'b1;
          pbyte = s.h0;
          if (s.crcb != hdlcr_pkg::CRC_GOOD)
            pcode = (s.bitcnt != 3'h0) ? hdlcr_pkg::PBC_BOTH : hdlcr_pkg::PBC_CRC;
          else
            pcode = (s.bitcnt != 3'h0) ? hdlcr_pkg::PBC_NONINT : hdlcr_pkg::PBC_GOOD;
          n.pkt = 1'b1;
        end
        n.st     = hdlcr_pkg::HDLCR_FRAME;
        n.crc    = hdlcr_pkg::CRC_INIT;
        n.bitcnt = 3'h0;
        n.nb     = 2'h0;
        n.first  = 1'b1;
        n.ones   = 3'h0;
      end else if (s.win == hdlcr_pkg::ABORT_SEQ) begin
        n.skip = hdlcr_pkg::SKIP_SEQ;
        n.st   = hdlcr_pkg::HDLCR_HUNT;
        if (s.active) begin
          push     = 1'b1;
          pcode    = hdlcr_pkg::PBC_DOWN;
          n.active = 1'b0;
          n.lc     = 1'b1;
        end
      end else if (s.skip != 4'h0) begin
        n.skip = s.skip - 4'h1;
      end else if (s.st == hdlcr_pkg::HDLCR_FRAME) begin
        if (s.ones == hdlcr_pkg::STUFF_RUN && !ob) begin
          n.ones = 3'h0;
        end else begin
          n.ones   = !ob ? 3'h0 : ((s.ones == hdlcr_pkg::STUFF_RUN) ? s.ones : s.ones + 3'h1);
          fb       = s.crc[0] ^ ob;
          n.crc    = {1'b0, s.crc[15:1]} ^ (fb ? hdlcr_pkg::CRC_POLY : 16'h0000);
          n.sh     = cand;
          n.bitcnt = s.bitcnt + 3'h1;
          if (s.bitcnt == 3'h7) begin
            n.first = 1'b0;
            // residue kept at the byte boundary so trailing odd bits do not spoil it
            n.crcb  = n.crc;
            if (s.first && s.cfg[hdlcr_pkg::CFG_MATCH] && !hit) begin
              n.st = hdlcr_pkg::HDLCR_DROP;
            end else begin
              // last two bytes are fcs, so three are held back
              if (s.nb == hdlcr_pkg::HOLD_LAST) begin
                push  = 1'b1;
                pbyte = s.h0;
              end else begin
                n.nb = s.nb + 2'h1;
              end
              n.h0 = s.h1;
              n.h1 = s.h2;
              n.h2 = cand;
            end
          end
        end
      end
    end

    // ---------------------------------------------------------------
    // fifo write and event interrupts
    // ---------------------------------------------------------------
    push_ok = push && (s.cnt != DEPTH_C || pop);
    if (push && !push_ok) begin
      n.overrun = 1'b1;
      n.irqp = 1'b1;
    end
    if (push_ok) begin
      n.mem[s.wp] = {pcode, pbyte};
      n.wp        = s.wp + 1'b1;
      if (pcode != hdlcr_pkg::PBC_DATA) n.irqp = 1'b1;
      if (CW'(s.cnt + ONE_C) == thr) n.irqp = 1'b1;
    end
    if (push_ok && !pop) n.cnt = s.cnt + ONE_C;
    else if (!push_ok && pop) n.cnt = s.cnt - ONE_C;

    // ---------------------------------------------------------------
    // resets of the receive path
    // ---------------------------------------------------------------
    if (rst_rx) begin
      n.st     = hdlcr_pkg::HDLCR_HUNT;
      n.active = 1'b0;
      n.win    = 8'h00;
      n.skip   = 4'h0;
      n.ones   = 3'h0;
      n.wp     = '0;
      n.rp     = '0;
      n.cnt    = '0;
    end
    if (!s.cfg[hdlcr_pkg::CFG_EN] || s.cfg[hdlcr_pkg::CFG_TERM]) begin
      n.lc      = 1'b0;
      n.pkt     = 1'b0;
      n.overrun = 1'b0;
      n.irqp = 1'b0;
    end
    if (s.overrun) begin
      n.lc  = 1'b0;
      n.pkt = 1'b0;
    end
    if (s.cfg[hdlcr_pkg::CFG_TERM]) n.cfg[hdlcr_pkg::CFG_TERM] = 1'b0;
    n.irq_n = ~irq_raw;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s       <= '0;
      s.cfg   <= hdlcr_pkg::CFG_RST;
      s.irqc  <= hdlcr_pkg::IRQC_RST;
      s.pri   <= hdlcr_pkg::PRI_RST;
      s.sec   <= hdlcr_pkg::SEC_RST;
      s.wt    <= 1'b1;
      s.irq_n <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  assign avs_readdata    = {24'h000000, s.rdata};
  assign avs_waitrequest = s.wt;
  assign irq_out_n       = s.irq_n;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  property p_disable_flush;
    ce && !s.cfg[hdlcr_pkg::CFG_EN] |=> s.cnt == '0 && !s.irqp && !s.lc && s.st == hdlcr_pkg::HDLCR_HUNT;
  endproperty
  a_disable_flush: assert property (p_disable_flush)
    else $error("disabled receiver not flushed");

  property p_terminate;
    ce && s.cfg[hdlcr_pkg::CFG_TERM] |=> !s.cfg[hdlcr_pkg::CFG_TERM] && s.cnt == '0 && !s.active;
  endproperty
  a_terminate: assert property (p_terminate)
    else $error("terminate did not restart receiver");

  property p_fill_irq;
    ce && push_ok && (CW'(s.cnt + ONE_C) == thr) |=> s.irqp;
  endproperty
  a_fill_irq: assert property (p_fill_irq)
    else $error("fill threshold interrupt missing");

  property p_irq_out;
    ce |=> irq_out_n == !$past(irq_raw);
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("interrupt output not gated by enable");

  property p_end_sets;
    ce && push_ok && pcode[2] |=> s.pkt && s.irqp;
  endproperty
  a_end_sets: assert property (p_end_sets)
    else $error("packet end did not set flags");

  property p_link_up;
    ce && push_ok && pcode == hdlcr_pkg::PBC_UP |=> s.lc && s.irqp && s.active;
  endproperty
  a_link_up: assert property (p_link_up)
    else $error("first flag not reported");

  property p_overrun_hold;
    ce && s.overrun |=> !s.lc && !s.pkt && s.cnt == '0;
  endproperty
  a_overrun_hold: assert property (p_overrun_hold)
    else $error("overrun did not hold fifo in reset");

  property p_empty;
    ce && pop && s.cnt == ONE_C && !push_ok |=> s.cnt == '0;
  endproperty
  a_empty: assert property (p_empty)
    else $error("fifo not empty after last read");

  property p_wait_one;
    ce && !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low for more than one cycle");
endmodule : hdlcr_rx

/* verif/hdlcr_framer.sv */
`timescale 1ns/1ns
module hdlcr_framer (
  input  wire logic ref_clk,
  output logic      dl_data,
  output logic      dl_valid
);
  logic [2:0] ones;

  initial begin
    dl_data = 1'b0;
    dl_valid = 1'b0;
    ones = 3'h0;
  end

  // ---------------------------------------------------------------
  // bit level
  // ---------------------------------------------------------------
  task automatic bit_out(input logic b);
    @(posedge ref_clk);
    dl_data <= b;
    dl_valid <= 1'b1;
    @(posedge ref_clk);
    dl_valid <= 1'b0;
    dl_data <= ~b;  // no stale level between strobes
  endtask : bit_out

  task automatic byte_out(input logic [7:0] v, input int n, input logic stuff);
    for (int i = 0; i < n; i++) begin  // lsb first
      bit_out(v[i]);
      ones = v[i] ? ones + 3'h1 : 3'h0;
      if (stuff && ones == 3'h5) begin
        bit_out(1'b0);  // zero after five ones
        ones = 3'h0;
      end
    end
  endtask : byte_out

  // ---------------------------------------------------------------
  // framing
  // ---------------------------------------------------------------
  // two flags: the receiver needs one more bit to see the first
  task automatic flag_out();
    byte_out(hdlcr_pkg::FLAG_SEQ, 8, 1'b0);
    byte_out(hdlcr_pkg::FLAG_SEQ, 8, 1'b0);
    ones = 3'h0;
  endtask : flag_out

  task automatic abort_out();
    byte_out(8'hFE, 8, 1'b0);
    byte_out(8'hFF, 8, 1'b0);
    ones = 3'h0;
  endtask : abort_out

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      c = (c >> 1) ^ ((c[0] ^ b[i]) ? hdlcr_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction : crc_step

  task automatic frame_out(input logic [7:0] q[$], input logic bad, input logic odd);
    logic [15:0] crc;
    crc = hdlcr_pkg::CRC_INIT;
    foreach (q[i]) begin
      byte_out(q[i], 8, 1'b1);
      crc = crc_step(crc, q[i]);
    end
    crc = ~crc;
    crc[0] = crc[0] ^ bad;  // corrupt fcs on request
    byte_out(crc[7:0], 8, 1'b1);
    byte_out(crc[15:8], 8, 1'b1);
    if (odd)
      byte_out(8'h05, 3, 1'b1);  // leftover bits
    flag_out();
  endtask : frame_out
endmodule : hdlcr_framer

/* verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic                         ref_clk = 1'b0;
  logic                         rstn = 1'b0;
  logic                         ce = 1'b1;
  logic [hdlcr_pkg::ADDR_W-1:0] avs_address = '0;
  logic                         avs_read = 1'b0;
  logic                         avs_write = 1'b0;
  logic [hdlcr_pkg::DATA_W-1:0] avs_writedata = '0;
  logic [3:0]                   avs_byteenable = 4'hF;
  logic [hdlcr_pkg::DATA_W-1:0] avs_readdata;
  logic                         avs_waitrequest, dl_data, dl_valid, irq_out_n;
  int                           fail_count = 0;
  int                           checks_done = 0;
  logic [31:0]                  lfsr = 32'h2932A7F1;
  logic [7:0]                   r, a;
  logic [2:0]                   code;
  logic [7:0]                   q[$];
  logic [7:0]                   lst [6] = '{8'h12, 8'h13, 8'h37, 8'hFF, 8'hFC, 8'h56};

  always #4 ref_clk = ~ref_clk;

  hdlcr_rx u_hdlcr_rx (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dl_data(dl_data), .dl_valid(dl_valid), .irq_out_n(irq_out_n)
  );
  hdlcr_framer u_hdlcr_framer (.ref_clk(ref_clk), .dl_data(dl_data), .dl_valid(dl_valid));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks_done %0d fail_count %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] rd);
    @(posedge ref_clk);
    avs_address <= {idx, 2'h0};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    // a hung access is ended by the watchdog only
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, r);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] m, input string what);
    bus(1'b0, idx, 8'h00, r);
    check(what, r & m, exp);
  endtask : rdc

  // reads until empty; the code of the last byte stays in status
  task automatic drain(output logic [2:0] c);
    logic [7:0] s;
    bus(1'b0, hdlcr_pkg::IDX_STAT, 8'h00, s);
    for (int i = 0; i < 200 && !s[7]; i++) begin
      bus(1'b0, hdlcr_pkg::IDX_DATA, 8'h00, r);
      bus(1'b0, hdlcr_pkg::IDX_STAT, 8'h00, s);
    end
    c = s[3:1];
  endtask : drain

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd

  function automatic logic keep(input logic [7:0] x, input logic match_on, input logic mask_on);
    logic [7:0] m;
    m = mask_on ? 8'hFC : 8'hFF;
    return !match_on || (x & m) == (8'h12 & m) || (x & m) == (8'h34 & m) || (x & m) == m;
  endfunction : keep

  task automatic mkq(input int n, input logic [7:0] first);
    q.delete();
    q.push_back(first);
    repeat (n - 1) q.push_back(rnd());
  endtask : mkq

  task automatic up();
    u_hdlcr_framer.flag_out();
    repeat (40) @(posedge ref_clk);
  endtask : up

  // ---------------------------------------------------------------
  // watchdog, longest run is well under this
  // ---------------------------------------------------------------
  initial begin
    #480000;
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rdc(hdlcr_pkg::IDX_CFG, 8'h00, 8'hFF, "config");
    rdc(hdlcr_pkg::IDX_IRQC, 8'h00, 8'hFF, "irq control");
    rdc(hdlcr_pkg::IDX_PRI, 8'hFF, 8'hFF, "primary");
    rdc(hdlcr_pkg::IDX_SEC, 8'hFF, 8'hFF, "secondary");
    rdc(hdlcr_pkg::IDX_STAT, 8'h80, 8'hF1, "status");
    rdc(8'hC6, 8'h00, 8'hFF, "unmapped");
    avs_byteenable <= 4'h0;
    wr(hdlcr_pkg::IDX_CFG, 8'h01);
    avs_byteenable <= 4'hF;
    rdc(hdlcr_pkg::IDX_CFG, 8'h00, 8'hFF, "masked write");
    check("irq pin", {7'h0, irq_out_n}, 8'h01);
    $display("test reset done");
    // level 0 means 128, so only level 3 fires; the window lags one byte, so seven sent store three
    for (int k = 0; k < 2; k++) begin
      wr(hdlcr_pkg::IDX_CFG, 8'h00);
      rdc(hdlcr_pkg::IDX_STAT, 8'h80, 8'hF1, "off");
      wr(hdlcr_pkg::IDX_IRQC, k ? 8'h83 : 8'h00);
      wr(hdlcr_pkg::IDX_CFG, 8'h01);
      up();
      check("irq pin", {7'h0, irq_out_n}, k ? 8'h00 : 8'h01);
      rdc(hdlcr_pkg::IDX_STAT, 8'h21, 8'hF1, "link up");
      rdc(hdlcr_pkg::IDX_DATA, 8'h00, 8'hFF, "dummy");
      rdc(hdlcr_pkg::IDX_STAT, 8'h82, 8'h8E, "up code");
      repeat (7) u_hdlcr_framer.byte_out(rnd(), 8, 1'b1);
      repeat (40) @(posedge ref_clk);
      rdc(hdlcr_pkg::IDX_STAT, k ? 8'h01 : 8'h00, 8'hF1, "fill");
      u_hdlcr_framer.abort_out();
      repeat (40) @(posedge ref_clk);
      rdc(hdlcr_pkg::IDX_STAT, 8'h21, 8'h71, "link down");
      drain(code);
      check("down code", {5'h0, code}, 8'h02);
    end
    $display("test levels done");
    up();
    drain(code);
    for (int m = 0; m < 4; m++) begin
      mkq(3 + rnd() % 6, rnd());
      u_hdlcr_framer.frame_out(q, m[0], m[1]);
      repeat (40) @(posedge ref_clk);
      rdc(hdlcr_pkg::IDX_STAT, 8'h11, 8'h71, "packet");
      foreach (q[i]) begin
        rdc(hdlcr_pkg::IDX_DATA, q[i], 8'hFF, "byte");
        rdc(hdlcr_pkg::IDX_STAT, (i == q.size() - 1) ? {4'h0, 1'b1, m[0], m[1], 1'b0} : 8'h00, 8'h0E,
            "code");
      end
      rdc(hdlcr_pkg::IDX_STAT, 8'h80, 8'hF1, "drained");
    end
    $display("test codes done");
    wr(hdlcr_pkg::IDX_PRI, 8'h12);
    wr(hdlcr_pkg::IDX_SEC, 8'h34);
    for (int k = 0; k < 14; k++) begin
      a = (k < 12) ? lst[k >> 1] : rnd();
      wr(hdlcr_pkg::IDX_CFG, {4'h0, k < 12, k[0], 2'h1});
      mkq(3, a);
      u_hdlcr_framer.frame_out(q, 1'b0, 1'b0);
      repeat (40) @(posedge ref_clk);
      rdc(hdlcr_pkg::IDX_STAT, keep(a, k < 12, k[0]) ? 8'h11 : 8'h80, 8'hF1, "match");
      drain(code);
    end
    $display("test match done");
    wr(hdlcr_pkg::IDX_CFG, 8'h01);
    repeat (2) u_hdlcr_framer.byte_out(rnd(), 8, 1'b1);
    wr(hdlcr_pkg::IDX_CFG, 8'h03);
    rdc(hdlcr_pkg::IDX_CFG, 8'h01, 8'hFF, "terminate");
    rdc(hdlcr_pkg::IDX_STAT, 8'h80, 8'hF1, "restart");
    up();
    rdc(hdlcr_pkg::IDX_STAT, 8'h21, 8'hF1, "relink");
    drain(code);
    $display("test terminate done");
    wr(hdlcr_pkg::IDX_CFG, 8'h00);
    wr(hdlcr_pkg::IDX_IRQC, 8'h80);
    wr(hdlcr_pkg::IDX_CFG, 8'h01);
    up();
    drain(code);
    mkq(140, rnd());
    u_hdlcr_framer.frame_out(q, 1'b0, 1'b0);
    repeat (40) @(posedge ref_clk);
    rdc(hdlcr_pkg::IDX_STAT, 8'hC1, 8'hF1, "overrun");
    rdc(hdlcr_pkg::IDX_STAT, 8'h80, 8'hF1, "overrun cleared");
    $display("test overrun done");
    // clock enable low: strobes are lost, nothing is detected
    ce <= 1'b0;
    up();
    ce <= 1'b1;
    rdc(hdlcr_pkg::IDX_STAT, 8'h80, 8'hF1, "frozen");
    $display("test enable done");
    give_verdict();
  end
endmodule : tb_top
